/* File: core/bfp_params.svh */
// Constants of the ballast fault supervisor: offsets, resets, timing
`ifndef BFP_PARAMS_SVH
`define BFP_PARAMS_SVH
// ---------------------------------------------------------------
// Clock and time base
// ---------------------------------------------------------------
`define BFP_CLK_MHZ 200
`define BFP_US_CYC (`BFP_CLK_MHZ)
`define BFP_OCP_NS 400
`define BFP_OCP_CYC ((`BFP_OCP_NS * `BFP_CLK_MHZ) / 1000)
`define BFP_MILD_US 500000
`define BFP_SEV_US 610
`define BFP_LAMP_OVERVOLTAGE_FAULT_WIN_US 40
`define BFP_RECTIFIER_EFFECT_FAULT_WIN_US 4000
`define BFP_SS_US 10000
`define BFP_IGN_US 235000
`define BFP_PRERUN_US 1000
`define BFP_LAMP_OVERVOLTAGE_FAULT_LIM 15
`define BFP_RECTIFIER_EFFECT_FAULT_LIM 128
// ---------------------------------------------------------------
// Register offsets and reset values
// ---------------------------------------------------------------
`define BFP_REG_CTRL 8'h00
`define BFP_REG_PREHEAT 8'h04
`define BFP_REG_STATUS 8'h08
`define BFP_REG_INT_STAT 8'h0C
`define BFP_REG_INT_MASK 8'h10
`define BFP_REG_EOL_CNT 8'h14
`define BFP_CTRL_RST 1'h1
`define BFP_PREHEAT_RST 22'h07_A120
`define BFP_MASK_RST 5'h00
// Interrupt bit positions
`define BFP_INT_FAIL 0
`define BFP_INT_CAP 1
`define BFP_INT_LAMP_OVERVOLTAGE_FAULT 2
`define BFP_INT_RECTIFIER_EFFECT_FAULT 3
`define BFP_INT_RUN 4
`endif

/* File: core/bfp_pkg.sv */
// Types of the ballast fault supervisor
package bfp_pkg;
    // Inverter phases, one-hot
    typedef enum logic [6:0] {
        BFP_IDLE = 7'h01,
        BFP_SS = 7'h02,
        BFP_PRE = 7'h04,
        BFP_IGN = 7'h08,
        BFP_PRERUN = 7'h10,
        BFP_RUN = 7'h20,
        BFP_FAIL = 7'h40
    } bfp_phase_t;

    // Whole state of the supervisor
    typedef struct packed {
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic [7:0] us_div;
        bfp_phase_t phase;
        logic [21:0] ph_tmr;
        logic [7:0] ocp_cnt;
        logic [19:0] mild_cnt;
        logic [9:0] sev_cnt;
        logic [5:0] w1_cnt;
        logic [11:0] w2_cnt;
        logic e1_seen;
        logic e2_seen;
        logic [3:0] e1_cnt;
        logic [7:0] e2_cnt;
        logic [5:0] cause;
        logic lamp_gone;
        logic ctrl_en;
        logic [21:0] preheat;
        logic [4:0] int_stat;
        logic [4:0] int_mask;
        logic [31:0] prdata;
    } bfp_state_t;
endpackage : bfp_pkg

/* File: core/bfp_top.sv */
// Ballast fault supervisor with phase sequencer and APB registers
//
// Notes on behaviour
// - Half-bridge current above its limit for over 400ns forces failure.
// - In run mode a departure from zero voltage switching is flagged.
// - Mild capacitive load lasting over 500ms forces failure.
// - Severe capacitive load lasting 610us forces failure.
// - A positive or negative lamp overvoltage crossing is an event.
// - A peak ratio above 1.15 or below 0.85 is a rectifier event.
// - Events are grouped into 40us and 4ms evaluation windows.
// - Per fault type a counter rises on faulty windows, falls otherwise.
// - Failure follows when the counters reach 15 or 128.
// - Phases run softstart, preheat, ignition, pre-run and run.
// - Only some checks are armed before run; all are armed in run.
// - Failure stops both gate drives, lowers current, senses filaments.
// - Failure ends only by lamp removal and reinsertion or power cycle.
`timescale 1ns/1ps
`include "bfp_params.svh"

module bfp_top
    import bfp_pkg::*;
#(
    parameter int P_MILD_US = `BFP_MILD_US,
    parameter int P_SEV_US = `BFP_SEV_US,
    parameter int P_LAMP_OVERVOLTAGE_FAULT_WIN_US = `BFP_LAMP_OVERVOLTAGE_FAULT_WIN_US,
    parameter int P_RECTIFIER_EFFECT_FAULT_WIN_US = `BFP_RECTIFIER_EFFECT_FAULT_WIN_US,
    parameter int P_SS_US = `BFP_SS_US,
    parameter int P_IGN_US = `BFP_IGN_US,
    parameter int P_PRERUN_US = `BFP_PRERUN_US
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator event pins
    input wire logic half_bridge_current_sense,
    input wire logic cap_load_mild,
    input wire logic cap_load_severe,
    input wire logic lamp_voltage_sense_pos_ov,
    input wire logic lamp_voltage_sense_neg_ov,
    input wire logic lamp_voltage_sense_ratio_hi,
    input wire logic lamp_voltage_sense_ratio_lo,
    input wire logic run_freq_reached,
    input wire logic lamp_present,
    // Power stage control
    output logic gate_drive_en,
    output logic low_current_mode,
    output logic filament_detect_en,
    output logic fail_mode,
    // Interrupt
    output logic irq
);

    bfp_state_t s_ff;
    bfp_state_t nxt_s;
    logic tick;
    logic setup;
    logic access;
    logic i_ocp, i_mild, i_sev, i_ov, i_rect, i_rfr, i_lamp;
    logic arm_ocp, arm_run, restart;
    logic w1_end, w2_end;
    logic [5:0] fault;
    logic [4:0] ev;
    logic mapped;

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Gate drive off and low-current sensing in failure or idle
    assign gate_drive_en = ~(s_ff.phase == BFP_IDLE
                             || s_ff.phase == BFP_FAIL);
    assign low_current_mode = ~gate_drive_en;
    assign filament_detect_en = ~gate_drive_en;
    assign fail_mode = (s_ff.phase == BFP_FAIL);
    assign irq = |(s_ff.int_stat & s_ff.int_mask);
    assign prdata = s_ff.prdata;
    assign pready = 1'b1;
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (paddr == `BFP_REG_CTRL) || (paddr == `BFP_REG_PREHEAT)
        || (paddr == `BFP_REG_STATUS) || (paddr == `BFP_REG_INT_STAT)
        || (paddr == `BFP_REG_INT_MASK) || (paddr == `BFP_REG_EOL_CNT);
    assign pslverr = access & ~mapped;

    // Synchronised pin levels
    assign i_ocp = s_ff.sync2[0];
    assign i_mild = s_ff.sync2[1];
    assign i_sev = s_ff.sync2[2];
    assign i_ov = s_ff.sync2[3] | s_ff.sync2[4];
    assign i_rect = s_ff.sync2[5] | s_ff.sync2[6];
    assign i_rfr = s_ff.sync2[7];
    assign i_lamp = s_ff.sync2[8];

    // Arming per phase: current limit from preheat on, rest in run
    assign arm_ocp = (s_ff.phase == BFP_PRE) || (s_ff.phase == BFP_IGN)
        || (s_ff.phase == BFP_PRERUN) || (s_ff.phase == BFP_RUN);
    assign arm_run = (s_ff.phase == BFP_RUN);
    assign tick = (s_ff.us_div == 8'(`BFP_US_CYC - 1));
    assign w1_end = tick && (s_ff.w1_cnt == 6'(P_LAMP_OVERVOLTAGE_FAULT_WIN_US - 1));
    assign w2_end = tick && (s_ff.w2_cnt == 12'(P_RECTIFIER_EFFECT_FAULT_WIN_US - 1));

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        fault = 6'h00;
        ev = 5'h00;
        restart = 1'b0;
        nxt_s.sync1 = {lamp_present, run_freq_reached,
            lamp_voltage_sense_ratio_lo, lamp_voltage_sense_ratio_hi,
            lamp_voltage_sense_neg_ov, lamp_voltage_sense_pos_ov,
            cap_load_severe, cap_load_mild, half_bridge_current_sense};
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.us_div = tick ? 8'h00 : s_ff.us_div + 8'h01;

        // Current limit: continuous high count in clock cycles
        if (arm_ocp && i_ocp) begin
            if (s_ff.ocp_cnt == 8'(`BFP_OCP_CYC)) begin
                fault[0] = 1'b1;
            end else begin
                nxt_s.ocp_cnt = s_ff.ocp_cnt + 8'h01;
            end
        end else begin
            nxt_s.ocp_cnt = 8'h00;
        end

        // Capacitive load grades, run mode only
        if (arm_run && (i_mild || i_sev)) begin
            ev[`BFP_INT_CAP] = 1'b1;
        end
        if (arm_run && i_mild) begin
            if (tick && s_ff.mild_cnt == 20'(P_MILD_US)) begin
                fault[1] = 1'b1;
            end else if (tick) begin
                nxt_s.mild_cnt = s_ff.mild_cnt + 20'h0_0001;
            end
        end else begin
            nxt_s.mild_cnt = 20'h0_0000;
        end
        if (arm_run && i_sev) begin
            if (tick && s_ff.sev_cnt == 10'(P_SEV_US - 1)) begin
                fault[2] = 1'b1;
            end else if (tick) begin
                nxt_s.sev_cnt = s_ff.sev_cnt + 10'h001;
            end
        end else begin
            nxt_s.sev_cnt = 10'h000;
        end

        // End-of-life windows and up/down counters
        if (arm_run) begin
            nxt_s.e1_seen = s_ff.e1_seen | i_ov;
            nxt_s.e2_seen = s_ff.e2_seen | i_rect;
            if (tick) begin
                nxt_s.w1_cnt = w1_end ? 6'h00 : s_ff.w1_cnt + 6'h01;
                nxt_s.w2_cnt = w2_end ? 12'h000 : s_ff.w2_cnt + 12'h001;
            end
            if (w1_end) begin
                nxt_s.e1_seen = 1'b0;
                if (s_ff.e1_seen) begin
                    ev[`BFP_INT_LAMP_OVERVOLTAGE_FAULT] = 1'b1;
                    nxt_s.e1_cnt = s_ff.e1_cnt + 4'h1;
                    if (s_ff.e1_cnt == 4'(`BFP_LAMP_OVERVOLTAGE_FAULT_LIM - 1)) begin
                        fault[3] = 1'b1;
                    end
                end else if (s_ff.e1_cnt != 4'h0) begin
                    nxt_s.e1_cnt = s_ff.e1_cnt - 4'h1;
                end
            end
            if (w2_end) begin
                nxt_s.e2_seen = 1'b0;
                if (s_ff.e2_seen) begin
                    ev[`BFP_INT_RECTIFIER_EFFECT_FAULT] = 1'b1;
                    nxt_s.e2_cnt = s_ff.e2_cnt + 8'h01;
                    if (s_ff.e2_cnt == 8'(`BFP_RECTIFIER_EFFECT_FAULT_LIM - 1)) begin
                        fault[4] = 1'b1;
                    end
                end else if (s_ff.e2_cnt != 8'h00) begin
                    nxt_s.e2_cnt = s_ff.e2_cnt - 8'h01;
                end
            end
        end

        // Phase sequencer
        if (tick) begin
            nxt_s.ph_tmr = s_ff.ph_tmr + 22'h00_0001;
        end
        case (s_ff.phase)
            BFP_IDLE: begin
                if (s_ff.ctrl_en && i_lamp) begin
                    restart = 1'b1;
                end
            end
            BFP_SS: begin
                if (s_ff.ph_tmr == 22'(P_SS_US)) begin
                    nxt_s.phase = BFP_PRE;
                    nxt_s.ph_tmr = 22'h00_0000;
                end
            end
            BFP_PRE: begin
                if (s_ff.ph_tmr >= s_ff.preheat) begin
                    nxt_s.phase = BFP_IGN;
                    nxt_s.ph_tmr = 22'h00_0000;
                end
            end
            BFP_IGN: begin
                if (i_rfr) begin
                    nxt_s.phase = BFP_PRERUN;
                    nxt_s.ph_tmr = 22'h00_0000;
                end else if (s_ff.ph_tmr == 22'(P_IGN_US)) begin
                    fault[5] = 1'b1;
                end
            end
            BFP_PRERUN: begin
                if (s_ff.ph_tmr == 22'(P_PRERUN_US)) begin
                    nxt_s.phase = BFP_RUN;
                    ev[`BFP_INT_RUN] = 1'b1;
                end
            end
            BFP_RUN: begin
                nxt_s.ph_tmr = s_ff.ph_tmr;
            end
            BFP_FAIL: begin
                nxt_s.ph_tmr = s_ff.ph_tmr;
                // Latched: leave only after removal then reinsertion
                if (!i_lamp) begin
                    nxt_s.lamp_gone = 1'b1;
                end else if (s_ff.lamp_gone) begin
                    restart = 1'b1;
                end
            end
            default: begin
                nxt_s.phase = BFP_IDLE;
            end
        endcase
        if (fault != 6'h00) begin
            nxt_s.phase = BFP_FAIL;
            nxt_s.cause = fault;
            nxt_s.lamp_gone = 1'b0;
            ev[`BFP_INT_FAIL] = 1'b1;
        end else if (gate_drive_en && !s_ff.ctrl_en) begin
            nxt_s.phase = BFP_IDLE;
        end
        if (restart) begin
            nxt_s.phase = BFP_SS;
            nxt_s.ph_tmr = 22'h00_0000;
            nxt_s.e1_cnt = 4'h0;
            nxt_s.e2_cnt = 8'h00;
            nxt_s.e1_seen = 1'b0;
            nxt_s.e2_seen = 1'b0;
            nxt_s.w1_cnt = 6'h00;
            nxt_s.w2_cnt = 12'h000;
            nxt_s.cause = 6'h00;
            nxt_s.lamp_gone = 1'b0;
        end

        // Register writes
        if (access && pwrite) begin
            case (paddr)
                `BFP_REG_CTRL: nxt_s.ctrl_en = pwdata[0];
                `BFP_REG_PREHEAT: nxt_s.preheat = pwdata[21:0];
                `BFP_REG_INT_MASK: nxt_s.int_mask = pwdata[4:0];
                default: nxt_s.ctrl_en = s_ff.ctrl_en;
            endcase
        end
        // Sticky events; a read clears, a new event wins
        if (access && !pwrite && paddr == `BFP_REG_INT_STAT) begin
            // Clear only the bits reported; later events survive
            nxt_s.int_stat = (s_ff.int_stat & ~s_ff.prdata[4:0]) | ev;
        end else begin
            nxt_s.int_stat = s_ff.int_stat | ev;
        end
        // Read data captured in the setup cycle
        if (setup) begin
            case (paddr)
                `BFP_REG_CTRL: nxt_s.prdata = {31'h0000_0000, s_ff.ctrl_en};
                `BFP_REG_PREHEAT: nxt_s.prdata = {10'h000, s_ff.preheat};
                `BFP_REG_STATUS:
                    nxt_s.prdata = {18'h0_0000, s_ff.cause, 1'b0, s_ff.phase};
                `BFP_REG_INT_STAT:
                    nxt_s.prdata = {27'h000_0000, s_ff.int_stat};
                `BFP_REG_INT_MASK:
                    nxt_s.prdata = {27'h000_0000, s_ff.int_mask};
                `BFP_REG_EOL_CNT:
                    nxt_s.prdata = {16'h0000, s_ff.e2_cnt, 4'h0, s_ff.e1_cnt};
                default: nxt_s.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_ff <= '0;
            s_ff.phase <= BFP_IDLE;
            s_ff.ctrl_en <= `BFP_CTRL_RST;
            s_ff.preheat <= `BFP_PREHEAT_RST;
            s_ff.int_mask <= `BFP_MASK_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_ocp_fail;
        @(posedge clk) disable iff (!resetn)
        (arm_ocp && i_ocp && s_ff.ocp_cnt == 8'(`BFP_OCP_CYC))
            |=> (s_ff.phase == BFP_FAIL);
    endproperty
    a_ocp_fail: assert property (p_ocp_fail)
        else $error("current limit did not force failure");

    property p_cap_flag;
        @(posedge clk) disable iff (!resetn)
        (arm_run && (i_mild || i_sev)) |=> s_ff.int_stat[`BFP_INT_CAP];
    endproperty
    a_cap_flag: assert property (p_cap_flag)
        else $error("capacitive load not flagged");

    property p_mild_fail;
        @(posedge clk) disable iff (!resetn)
        (arm_run && i_mild && tick && s_ff.mild_cnt == 20'(P_MILD_US))
            |=> (s_ff.phase == BFP_FAIL) && s_ff.cause[1];
    endproperty
    a_mild_fail: assert property (p_mild_fail)
        else $error("mild capacitive load did not fail");

    property p_sev_fail;
        @(posedge clk) disable iff (!resetn)
        (arm_run && i_sev && tick && s_ff.sev_cnt == 10'(P_SEV_US - 1))
            |=> (s_ff.phase == BFP_FAIL) && s_ff.cause[2];
    endproperty
    a_sev_fail: assert property (p_sev_fail)
        else $error("severe capacitive load did not fail");

    property p_eol_down;
        @(posedge clk) disable iff (!resetn)
        (arm_run && w2_end && !s_ff.e2_seen && s_ff.e2_cnt != 8'h00
            && fault == 6'h00) |=> (s_ff.e2_cnt == $past(s_ff.e2_cnt) - 8'h01);
    endproperty
    a_eol_down: assert property (p_eol_down)
        else $error("rectifier counter did not count down");

    property p_eol_floor;
        @(posedge clk) disable iff (!resetn)
        (arm_run && w1_end && !s_ff.e1_seen && s_ff.e1_cnt == 4'h0)
            |=> (s_ff.e1_cnt == 4'h0);
    endproperty
    a_eol_floor: assert property (p_eol_floor)
        else $error("overvoltage counter went below zero");

    property p_lamp_overvoltage_fault_fail;
        @(posedge clk) disable iff (!resetn)
        (arm_run && w1_end && s_ff.e1_seen
            && s_ff.e1_cnt == 4'(`BFP_LAMP_OVERVOLTAGE_FAULT_LIM - 1))
            |=> (s_ff.phase == BFP_FAIL) && s_ff.cause[3];
    endproperty
    a_lamp_overvoltage_fault_fail: assert property (p_lamp_overvoltage_fault_fail)
        else $error("overvoltage count limit did not fail");

    property p_arm;
        @(posedge clk) disable iff (!resetn)
        !arm_run |=> (s_ff.mild_cnt == 20'h0_0000)
            && (s_ff.sev_cnt == 10'h000);
    endproperty
    a_arm: assert property (p_arm)
        else $error("run-only check active outside run");

    property p_fail_out;
        @(posedge clk) disable iff (!resetn)
        (s_ff.phase == BFP_FAIL) |-> !gate_drive_en && low_current_mode
            && filament_detect_en;
    endproperty
    a_fail_out: assert property (p_fail_out)
        else $error("gate drive active in failure");

    property p_fail_hold;
        @(posedge clk) disable iff (!resetn)
        (s_ff.phase == BFP_FAIL && !s_ff.lamp_gone) |=>
            (s_ff.phase == BFP_FAIL);
    endproperty
    a_fail_hold: assert property (p_fail_hold)
        else $error("failure released without lamp removal");

endmodule : bfp_top

/* File: test/bfp_stage_model.sv */
// Behavioural model of the half-bridge stage and lamp sensing network
`timescale 1ns/1ps

module bfp_stage_model (
    // Power stage state from the supervisor
    input wire logic gate_drive_en,
    // Fault situations chosen by the bench
    input wire logic oc_cmd,
    input wire logic mild_cmd,
    input wire logic sev_cmd,
    input wire logic pos_cmd,
    input wire logic neg_cmd,
    input wire logic hi_cmd,
    input wire logic lo_cmd,
    input wire logic lamp_cmd,
    input wire logic ign_cmd,
    // Comparator and sense pins
    output logic half_bridge_current_sense,
    output logic cap_load_mild,
    output logic cap_load_severe,
    output logic lamp_voltage_sense_pos_ov,
    output logic lamp_voltage_sense_neg_ov,
    output logic lamp_voltage_sense_ratio_hi,
    output logic lamp_voltage_sense_ratio_lo,
    output logic run_freq_reached,
    output logic lamp_present
);
    // Comparators trip only while the bridge switches; a stopped bridge
    // carries no current, so a latched failure sees quiet pins
    assign half_bridge_current_sense = oc_cmd & gate_drive_en;
    assign cap_load_mild = mild_cmd & gate_drive_en;
    assign cap_load_severe = sev_cmd & gate_drive_en;
    assign lamp_voltage_sense_pos_ov = pos_cmd & gate_drive_en;
    assign lamp_voltage_sense_neg_ov = neg_cmd & gate_drive_en;
    assign lamp_voltage_sense_ratio_hi = hi_cmd & gate_drive_en;
    assign lamp_voltage_sense_ratio_lo = lo_cmd & gate_drive_en;
    assign run_freq_reached = ign_cmd & gate_drive_en;
    // Filament presence follows the inserted lamp
    assign lamp_present = lamp_cmd;
endmodule : bfp_stage_model

/* File: test/test_ballast_fault_protection.sv */
// Self-checking bench of the ballast fault supervisor
`timescale 1ns/1ps
`include "bfp_params.svh"

module test_ballast_fault_protection;
    import bfp_pkg::*;
    localparam int SEV = 10;
    localparam int MILD = 50;
    localparam int W1 = 4;
    localparam int W2 = 1;
    localparam int TK = 200;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, gate_drive_en, low_current_mode;
    logic filament_detect_en, fail_mode, irq;
    logic oc_cmd = 0, mild_cmd = 0, sev_cmd = 0, pos_cmd = 0, neg_cmd = 0;
    logic hi_cmd = 0, lo_cmd = 0, lamp_cmd = 0, ign_cmd = 1;
    logic hb_cs, c_mild, c_sev, v_pos, v_neg, v_hi, v_lo, rf, lp;
    logic [31:0] q;
    logic e;
    logic [6:0] seen;
    int bad, n, err_total = 0, check_count = 0;

    // Free-running 200 MHz clock
    always #2.5 clk = ~clk;

    bfp_stage_model u_stage (.gate_drive_en(gate_drive_en), .oc_cmd(oc_cmd),
        .mild_cmd(mild_cmd), .sev_cmd(sev_cmd), .pos_cmd(pos_cmd),
        .neg_cmd(neg_cmd), .hi_cmd(hi_cmd), .lo_cmd(lo_cmd),
        .lamp_cmd(lamp_cmd), .ign_cmd(ign_cmd),
        .half_bridge_current_sense(hb_cs), .cap_load_mild(c_mild),
        .cap_load_severe(c_sev), .lamp_voltage_sense_pos_ov(v_pos),
        .lamp_voltage_sense_neg_ov(v_neg), .lamp_voltage_sense_ratio_hi(v_hi),
        .lamp_voltage_sense_ratio_lo(v_lo), .run_freq_reached(rf),
        .lamp_present(lp));

    bfp_top #(.P_MILD_US(MILD), .P_SEV_US(SEV), .P_LAMP_OVERVOLTAGE_FAULT_WIN_US(W1),
        .P_RECTIFIER_EFFECT_FAULT_WIN_US(W2), .P_SS_US(10), .P_IGN_US(100), .P_PRERUN_US(5))
    DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .half_bridge_current_sense(hb_cs),
        .cap_load_mild(c_mild), .cap_load_severe(c_sev),
        .lamp_voltage_sense_pos_ov(v_pos), .lamp_voltage_sense_neg_ov(v_neg),
        .lamp_voltage_sense_ratio_hi(v_hi), .lamp_voltage_sense_ratio_lo(v_lo),
        .run_freq_reached(rf), .lamp_present(lp),
        .gate_drive_en(gate_drive_en), .low_current_mode(low_current_mode),
        .filament_detect_en(filament_detect_en), .fail_mode(fail_mode),
        .irq(irq));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task test_done;
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task rng(input int v, input int lo, input int hi);
        chk({31'd0, v >= lo && v <= hi}, 32'h0000_0001);
    endtask : rng

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            test_done();
        end
    endtask : xfer

    task rd_chk(input logic [7:0] a, input logic [31:0] m,
                input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(q & m, exp);
    endtask : rd_chk

    task wait_fail(input int lim);
        n = 0;
        while (fail_mode !== 1'b1) begin
            if (n == lim) begin
                err_total++;
                test_done();
            end
            @(posedge clk);
            n++;
        end
    endtask : wait_fail

    // Polls the phase, noting every phase met and any step backwards
    task wait_phase(input logic [6:0] ph);
        logic [6:0] last;
        int i;
        seen = 7'h00;
        last = 7'h01;
        bad = 0;
        q = 32'h0000_0000;
        for (i = 0; q[6:0] !== ph; i++) begin
            if (i == 9000) begin
                err_total++;
                test_done();
            end
            xfer(1'b0, `BFP_REG_STATUS, 32'h0000_0000);
            seen = seen | q[6:0];
            if (q[6:0] < last) bad++;
            last = q[6:0];
        end
    endtask : wait_phase

    // Lamp out and back in, then up to run mode
    task restart_run;
        lamp_cmd <= 1'b0;
        repeat (10) @(posedge clk);
        lamp_cmd <= 1'b1;
        // Let the pin pass its synchroniser before the first phase poll
        repeat (4) @(posedge clk);
        wait_phase(BFP_RUN);
        chk({25'd0, seen & 7'h36}, 32'h0000_0036);
        chk(bad, 0);
        rd_chk(`BFP_REG_EOL_CNT, 32'h0000_FF0F, 32'h0000_0000);
        rd_chk(`BFP_REG_INT_STAT, 32'h0000_0010, 32'h0000_0010);
    endtask : restart_run

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(`BFP_REG_CTRL, 32'h0000_0001, 32'h0000_0001);
        rd_chk(`BFP_REG_PREHEAT, 32'h003F_FFFF, 32'h0007_A120);
        rd_chk(`BFP_REG_STATUS, 32'h0000_3F7F, 32'h0000_0001);
        rd_chk(`BFP_REG_INT_MASK, 32'h0000_001F, 32'h0000_0000);
        rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        chk({31'd0, e}, 32'h0000_0001);
        xfer(1'b1, `BFP_REG_PREHEAT, 32'h0000_0010);
        lamp_cmd <= 1'b1;
        wait_phase(BFP_PRE);
        // Severe load and overvoltage are not armed in preheat
        sev_cmd <= 1'b1;
        pos_cmd <= 1'b1;
        repeat (2500) @(posedge clk);
        sev_cmd <= 1'b0;
        pos_cmd <= 1'b0;
        chk({31'd0, fail_mode}, 32'h0000_0000);
        rd_chk(`BFP_REG_EOL_CNT, 32'h0000_FF0F, 32'h0000_0000);
        // Overcurrent just short of the limit, then held
        oc_cmd <= 1'b1;
        repeat (78) @(posedge clk);
        oc_cmd <= 1'b0;
        repeat (20) @(posedge clk);
        chk({31'd0, fail_mode}, 32'h0000_0000);
        oc_cmd <= 1'b1;
        wait_fail(300);
        rng(n, 80, 90);
        oc_cmd <= 1'b0;
        @(posedge clk);
        chk({29'd0, gate_drive_en, low_current_mode, filament_detect_en},
            32'h0000_0003);
        chk({31'd0, irq}, 32'h0000_0000);
        repeat (100) @(posedge clk);
        chk({31'd0, fail_mode}, 32'h0000_0001);
        rd_chk(`BFP_REG_STATUS, 32'h0000_3F7F, 32'h0000_0140);
        xfer(1'b1, `BFP_REG_INT_MASK, 32'h0000_001F);
        @(posedge clk);
        chk({31'd0, irq}, 32'h0000_0001);
        rd_chk(`BFP_REG_INT_STAT, 32'h0000_001F, 32'h0000_0001);
        @(posedge clk);
        chk({31'd0, irq}, 32'h0000_0000);
        xfer(1'b1, `BFP_REG_PREHEAT, 32'h0000_0002);
        // Severe capacitive load in run
        restart_run();
        sev_cmd <= 1'b1;
        wait_fail(SEV * TK + 300);
        sev_cmd <= 1'b0;
        rng(n, (SEV - 1) * TK, (SEV + 1) * TK + 10);
        rd_chk(`BFP_REG_INT_STAT, 32'h0000_0003, 32'h0000_0003);
        rd_chk(`BFP_REG_STATUS, 32'h0000_3F7F, 32'h0000_0440);
        // Mild capacitive load in run
        restart_run();
        mild_cmd <= 1'b1;
        wait_fail(MILD * TK + 300);
        mild_cmd <= 1'b0;
        rng(n, (MILD - 1) * TK, (MILD + 1) * TK + 10);
        rd_chk(`BFP_REG_STATUS, 32'h0000_3F7F, 32'h0000_0240);
        // Overvoltage windows count up, down to zero, then to the limit
        restart_run();
        pos_cmd <= 1'b1;
        repeat (5 * W1 * TK) @(posedge clk);
        pos_cmd <= 1'b0;
        xfer(1'b0, `BFP_REG_EOL_CNT, 32'h0000_0000);
        rng(q[3:0], 4, 6);
        chk({31'd0, fail_mode}, 32'h0000_0000);
        rd_chk(`BFP_REG_INT_STAT, 32'h0000_0004, 32'h0000_0004);
        repeat (8 * W1 * TK) @(posedge clk);
        rd_chk(`BFP_REG_EOL_CNT, 32'h0000_000F, 32'h0000_0000);
        neg_cmd <= 1'b1;
        wait_fail(20 * W1 * TK);
        neg_cmd <= 1'b0;
        rng(n, 13 * W1 * TK, 15 * W1 * TK + 20);
        rd_chk(`BFP_REG_STATUS, 32'h0000_3F7F, 32'h0000_0840);
        // Rectifier windows up to the limit of 128
        restart_run();
        hi_cmd <= 1'b1;
        repeat (3 * W2 * TK) @(posedge clk);
        hi_cmd <= 1'b0;
        lo_cmd <= 1'b1;
        xfer(1'b0, `BFP_REG_EOL_CNT, 32'h0000_0000);
        rng(q[15:8], 2, 5);
        chk({28'd0, q[3:0]}, 32'h0000_0000);
        wait_fail(130 * W2 * TK);
        lo_cmd <= 1'b0;
        rng(n, 121 * W2 * TK, 127 * W2 * TK);
        rd_chk(`BFP_REG_STATUS, 32'h0000_3F7F, 32'h0000_1040);
        rd_chk(`BFP_REG_INT_STAT, 32'h0000_0009, 32'h0000_0009);
        lamp_cmd <= 1'b0;
        repeat (10) @(posedge clk);
        lamp_cmd <= 1'b1;
        wait_phase(BFP_SS);
        rd_chk(`BFP_REG_STATUS, 32'h0000_3F00, 32'h0000_0000);
        rd_chk(`BFP_REG_EOL_CNT, 32'h0000_FF0F, 32'h0000_0000);
        test_done();
    end
endmodule : test_ballast_fault_protection
